/* File: asrc_host.v */
// host side controller driving a 4k by 4 asynchronous static ram
`timescale 1ns/100ps
`default_nettype none
`include "asrc_consts.vh"
module asrc_host
#(
    parameter ADDR_W = `ASRC_ADDR_W,          // word select width
    parameter DATA_W = `ASRC_DATA_W           // word width
)
(
    input  wire              clk,
    input  wire              sys_rst,
    input  wire              reqValid,        // user request strobe
    input  wire              reqWrite,        // 1 write, 0 read
    input  wire [ADDR_W-1:0] reqAddr,         // word address
    input  wire [DATA_W-1:0] reqWdata,        // write data
    output reg               reqReady,        // idle, can take request
    output reg               rspValid,        // one-cycle completion
    output reg  [DATA_W-1:0] rspRdata,        // read word
    output reg               selectN,         // chip select, low active
    output reg               strobeN,         // write strobe, low active
    output reg  [ADDR_W-1:0] wordSelectLines, // address pins
    output reg  [DATA_W-1:0] dataOut,         // data pin drive value
    output reg               dataOeN,         // low while host drives
    input  wire [DATA_W-1:0] dataIn           // data pin level
);
    // request sequence, one at a time:
    //   read : select low with the address, wait the access time,
    //          sample the pins, select high and report
    //   write: select and strobe low together, wait until the ram has let
    //          go of the pins, drive data, raise strobe, release, deselect
    // ready drops on the edge a request is taken and returns with the
    // report, so a new request can be taken right after

    // wait lengths in whole cycles, least times rounded up; kept as
    // integers so the 32-bit division never lands in a narrow count
    localparam integer ACC_CYC  = `ASRC_CEIL(`ASRC_SEL_ACCESS_PS);
    localparam integer WZ_CYC   = `ASRC_CEIL(`ASRC_WZ_PS);
    localparam integer DW_CYC   = `ASRC_CEIL(`ASRC_DW_PS);
    localparam integer WP_CYC   = `ASRC_CEIL(`ASRC_WP_PS);
    localparam integer AW_CYC   = `ASRC_CEIL(`ASRC_AW_PS);
    localparam integer HOLD_CYC = `ASRC_CEIL(`ASRC_DH_PS);

    // counter loads, cut to the counter width on purpose
    localparam [`ASRC_CNT_W-1:0] T_ACC  = ACC_CYC[`ASRC_CNT_W-1:0];
    localparam [`ASRC_CNT_W-1:0] T_WZ   = WZ_CYC[`ASRC_CNT_W-1:0];
    localparam [`ASRC_CNT_W-1:0] T_DW   = DW_CYC[`ASRC_CNT_W-1:0];
    localparam [`ASRC_CNT_W-1:0] T_WP   = WP_CYC[`ASRC_CNT_W-1:0];
    localparam [`ASRC_CNT_W-1:0] T_AW   = AW_CYC[`ASRC_CNT_W-1:0];
    localparam [`ASRC_CNT_W-1:0] T_HOLD = HOLD_CYC[`ASRC_CNT_W-1:0];

    // the counter spends one cycle more than it is loaded with, so the
    // hold load is one less: the pins go free one cycle after strobe
    // rise, before the ram can turn its outputs back on under select
    localparam [`ASRC_CNT_W-1:0] T_HOLD_LD = T_HOLD - 1'b1;

    // one-hot states
    localparam [5:0] S_IDLE  = 6'h01;         // deselected standby
    localparam [5:0] S_RD    = 6'h02;         // read access wait
    localparam [5:0] S_WZ    = 6'h04;         // strobe low, bus not ours
    localparam [5:0] S_WD    = 6'h08;         // data driven, pulse on
    localparam [5:0] S_WH    = 6'h10;         // strobe high, hold data
    localparam [5:0] S_REL   = 6'h20;         // release bus, deselect

    reg  [5:0]              state_q;
    reg  [5:0]              state_d;
    reg                     load;              // start wait counter
    reg  [`ASRC_CNT_W-1:0]  count;             // wait length
    wire                    done;              // wait finished
    wire                    take;              // request accepted here

    // a request is taken only in standby, with ready already shown
    assign take = reqValid && reqReady;

    // one wait counter serves every timed step; steps never overlap,
    // so sharing it costs nothing and keeps the counts in one place
    asrc_delay u_delay
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (load),
        .count   (count),
        .done    (done)
    );

    // write pulse must cover both data setup and strobe pulse width
    function [`ASRC_CNT_W-1:0] maxCnt;
        input [`ASRC_CNT_W-1:0] a;
        input [`ASRC_CNT_W-1:0] b;
        begin
            maxCnt = (a > b) ? a : b;
        end
    endfunction

    // next state and wait loading
    always @*
    begin
        state_d = state_q;
        load    = 1'b0;
        count   = {`ASRC_CNT_W{1'b0}};
        case (state_q)
            // standby: a taken request picks read or write
            S_IDLE:
            begin
                if (take)
                begin
                    load = 1'b1;
                    if (reqWrite)
                    begin
                        state_d = S_WZ;
                        count   = T_WZ;
                    end
                    else
                    begin
                        state_d = S_RD;
                        count   = T_ACC;
                    end
                end
            end
            // read: back to standby once the access time is over
            S_RD:
                if (done)
                    state_d = S_IDLE;
            // write, strobe low: the ram may still drive the pins
            S_WZ:
                if (done)
                begin
                    state_d = S_WD;
                    load    = 1'b1;
                    // strobe low long enough for pulse, address and data
                    count   = maxCnt(T_DW, maxCnt(T_WP, T_AW) - T_WZ);
                end
            // write, data driven: wait out the setup before strobe rise
            S_WD:
                if (done)
                begin
                    state_d = S_WH;
                    load    = 1'b1;
                    count   = T_HOLD_LD;
                end
            // write, strobe high: hold data, then release
            S_WH:
                if (done)
                    state_d = S_REL;
            // pins released: deselect and report on the next edge
            S_REL:
                state_d = S_IDLE;
            // unknown code: recover to standby
            default:
                state_d = S_IDLE;
        endcase
    end

    // pin and response registers; address only moves while select high
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            // standby pins: deselected, strobe high, bus released
            state_q         <= S_IDLE;
            reqReady        <= 1'b0;
            rspValid        <= 1'b0;
            rspRdata        <= {DATA_W{1'b0}};
            selectN         <= 1'b1;
            strobeN         <= 1'b1;
            wordSelectLines <= {ADDR_W{1'b0}};
            dataOut         <= {DATA_W{1'b0}};
            dataOeN         <= 1'b1;
        end
        else
        begin
            state_q  <= state_d;
            rspValid <= 1'b0;
            reqReady <= (state_d == S_IDLE);
            case (state_q)
                // standby: drive address, data and controls on a take
                S_IDLE:
                    if (take)
                    begin
                        // select, and strobe on a write, low in one edge: address set at start
                        wordSelectLines <= reqAddr;
                        dataOut         <= reqWdata;
                        selectN         <= 1'b0;
                        strobeN         <= !reqWrite;
                    end
                // read: sample the pins and deselect in one edge
                S_RD:
                    if (done)
                    begin
                        rspRdata <= dataIn;
                        rspValid <= 1'b1;
                        selectN  <= 1'b1;
                    end
                // ram has let go of the pins, start driving data
                S_WZ:
                    if (done)
                        dataOeN <= 1'b0;
                // setup met, end the write with the strobe
                S_WD:
                    if (done)
                        strobeN <= 1'b1;
                // hold met, free the pins while select is still low
                S_WH:
                    if (done)
                        dataOeN <= 1'b1;
                // deselect and report the finished write
                S_REL:
                begin
                    selectN  <= 1'b1;
                    rspValid <= 1'b1;
                end
                // unknown code: drop every control to its idle level
                default:
                begin
                    selectN <= 1'b1;
                    strobeN <= 1'b1;
                    dataOeN <= 1'b1;
                end
            endcase
        end
    end
endmodule // asrc_host
`default_nettype wire

/* File: asrc_consts.vh */
// timing and field constants for the async sram host controller
// Notes on behaviour
// - strobe high under select means read
// - write starts at later falling strobe
// - host drives data only after strobe-off time
// - address changes only with a strobe high
// - address 20 ns, data 10 ns before end
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH
`define ASRC_CLK_PS          4000
`define ASRC_SEL_ACCESS_PS   25000
`define ASRC_ADDR_ACCESS_PS  25000
`define ASRC_WZ_PS           15000
`define ASRC_WP_PS           20000
`define ASRC_DW_PS           10000
`define ASRC_DH_PS           3000
`define ASRC_WR_PS           2000
`define ASRC_AW_PS           20000
`define ASRC_CEIL(t)         (((t) + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_CNT_W           4
`define ASRC_ADDR_W          12
`define ASRC_DATA_W          4
`endif

/* File: asrc_delay.v */
// small down counter that flags when a programmed wait is over
`timescale 1ns/100ps
`default_nettype none
`include "asrc_consts.vh"
module asrc_delay
(
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire                   load,       // start a new wait
    input  wire [`ASRC_CNT_W-1:0] count,      // cycles to wait
    output wire                   done        // wait over
);
    reg [`ASRC_CNT_W-1:0] cnt_q;              // cycles left

    // load wins over counting so a back to back wait restarts cleanly
    always @(posedge clk)
    begin
        if (sys_rst)
            cnt_q <= {`ASRC_CNT_W{1'b0}};
        else if (load)
            cnt_q <= count;
        else if (cnt_q != {`ASRC_CNT_W{1'b0}})
            cnt_q <= cnt_q - 1'b1;
    end

    // flag from the count alone: a done that looked at load would loop
    // back through the caller, which loads on done
    assign done = (cnt_q == {`ASRC_CNT_W{1'b0}});
endmodule // asrc_delay
`default_nettype wire

/* File: asrc_host_chk.sv */
// pin-level checks for the sram host controller
`timescale 1ns/100ps
`default_nettype none
module asrc_host_chk #(parameter ADDR_W = 12)
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              rspValid,
    input wire logic              selectN,
    input wire logic              strobeN,
    input wire logic [ADDR_W-1:0] wordSelectLines,
    input wire logic              dataOeN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // write tail: release the pins, then deselect and report
    sequence s_wr_tail; dataOeN ##1 (selectN && rspValid); endsequence
    // a read keeps the bus free for the 32 ns access window
    a_read_cycle:
        assert property ($fell(selectN) && strobeN |->
            (strobeN && dataOeN && !selectN) [*8] ##1 (selectN && rspValid))
            else $error("read cycle shape");
    a_strobe_select:
        assert property (!strobeN |-> !selectN) else $error("stray strobe");
    a_no_contend:
        assert property ($fell(strobeN) |-> dataOeN [*4]) else $error("early");
    a_addr_steady:
        assert property (!$stable(wordSelectLines) |-> $past(selectN))
            else $error("address moved in cycle");
    a_data_setup:
        assert property ($rose(strobeN) |-> $past(dataOeN, 3) == 1'b0)
            else $error("late data");
    a_release_hold:
        assert property ($rose(strobeN) |=> s_wr_tail) else $error("release");
endmodule // asrc_host_chk
bind asrc_host asrc_host_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
    .sys_rst(sys_rst), .rspValid(rspValid), .selectN(selectN),
    .strobeN(strobeN), .wordSelectLines(wordSelectLines), .dataOeN(dataOeN));
`default_nettype wire

/* File: asrc_sram_model.sv */
// behavioural 4k by 4 static ram seen from its pins
`timescale 1ns/100ps
`default_nettype none
module asrc_sram_model #(parameter integer ACC = 25)
(
    input  wire logic        selectN,
    input  wire logic        strobeN,
    input  wire logic [11:0] addr,
    input  wire logic [3:0]  hostData,
    input  wire logic        hostOeN,
    output wire logic [3:0]  busLevel
);
    logic [3:0] mem [0:4095]; // one 4-bit word per address
    logic [3:0] q = 4'h0;     // sense output
    logic       on = 1'b0;    // ram drives the pins
    logic       junk = 1'b0;  // undriven pins wander, never hold
    initial foreach (mem[i]) mem[i] = 4'h0;
    always #4 junk = ~junk;
    assign busLevel = !hostOeN ? hostData : on ? q : {4{junk}};
    // old word lingers 3 ns, then garbage until the access is done
    always @(selectN or strobeN or addr)
    begin
        q <= #3 ~q;
        q <= #ACC mem[addr];
    end
    // output buffers follow select and strobe
    always @(selectN or strobeN)
        if (selectN)
            on <= #5 1'b0;
        else if (strobeN)
            on <= #5 1'b1;
        else
            on <= #15 1'b0;
    // whichever control rises first ends the write
    always @(posedge strobeN or posedge selectN)
        if (selectN !== strobeN)
            mem[addr] <= busLevel;
endmodule // asrc_sram_model
`default_nettype wire

/* File: asrc_host_test.sv */
// random traffic through the sram host controller
`timescale 1ns/100ps
`default_nettype none
module asrc_host_test;
    logic        clk = 1'b0;
    logic        sysRst, reqValid, reqWrite, reqReady, rspValid;
    logic        selectN, strobeN, dataOeN;
    logic [11:0] reqAddr, wordSelectLines;
    logic [3:0]  reqWdata, rspRdata, dataOut, dataIn;
    logic [3:0]  shadow [0:4095]; // words the ram should hold
    int          num_errors = 0, checked = 0;
    initial forever #2 clk = ~clk;
    asrc_host dut (.clk(clk), .sys_rst(sysRst), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
        .selectN(selectN), .strobeN(strobeN), .dataOut(dataOut),
        .wordSelectLines(wordSelectLines), .dataOeN(dataOeN), .dataIn(dataIn));
    asrc_sram_model ram (.selectN(selectN), .strobeN(strobeN),
        .addr(wordSelectLines), .hostData(dataOut), .hostOeN(dataOeN),
        .busLevel(dataIn));
    function automatic logic [3:0] expectRd(input logic [11:0] a);
        return shadow[a];
    endfunction
    task automatic results;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one request held until taken, then wait for completion
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [3:0] d);
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr  <= a;
        reqWdata <= d;
        @(negedge clk);
        while (reqReady !== 1'b1) @(negedge clk);
        @(posedge clk);
        reqValid <= 1'b0;
        repeat (20) if (rspValid !== 1'b1) @(negedge clk);
        checked++;
        if (rspValid !== 1'b1)
        begin
            $display("BAD rspValid expected 1 seen %b", rspValid);
            num_errors++;
        end
        else if (!w && rspRdata !== expectRd(a))
        begin
            $display("BAD rspRdata expected %h seen %h at %h", expectRd(a),
                rspRdata, a);
            num_errors++;
        end
        if (w)
            shadow[a] = d;
    endtask
    // a hang ends the run as a failure
    initial
    begin
        repeat (4000) @(posedge clk);
        num_errors++;
        results();
    end
    initial
    begin
        sysRst = 1'b1;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 12'h000;
        reqWdata = 4'h0;
        void'($urandom(32'h5C582092));
        foreach (shadow[i]) shadow[i] = 4'h0;
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        // array ends first, then a small hot range at random
        xfer(1'b1, 12'hFFF, 4'hA);
        xfer(1'b1, 12'h000, 4'h5);
        xfer(1'b0, 12'hFFF, 4'h0);
        xfer(1'b0, 12'h000, 4'h0);
        repeat (80) xfer(1'($urandom), 12'($urandom % 16), 4'($urandom));
        results();
    end
endmodule // asrc_host_test
`default_nettype wire
